//--- verilog/ratio_strap_device.sv
// Processor end: latches the core ratio code across reset, then passes
// the shared pins through as compatibility inputs.
// Assumes the board end drives the link in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Board changes bus clock only during reset
// - All timing referenced to bus clock rising edge
// - Latch code through reset plus two clocks
// - Afterwards pins are ordinary compatibility inputs
// - Board muxes straps by CMOS-domain reset
// - Unpowered straps default to 2x code
// - Reset-level select ignores compatibility inputs
// - One clocked mux per redundant pair
// - Sideband inputs synchronised in redundant mode
// - Board syncs sidebands except power-stable
// - Interrupt clock is quarter bus clock, in redundant mode only
module ratio_strap_device
    import ratio_strap_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link from board
    ratio_strap_if.device link,
    // Mode strap
    input wire logic redundant_pair_mode,
    // Core-side results
    output logic [STRAP_WIDTH-1:0] ratioCode,
    output logic ratioValid,
    output logic addr_wrap_mask_n,
    output logic ignore_numeric_error_n,
    output logic local_irq0_maskable,
    output logic local_irq1_nonmaskable,
    output logic powerStableSeen,
    output logic interruptTick
);
    localparam logic [1:0] HOLD_LAST = 2'(STRAP_HOLD_CLOCKS - 1);
    phase_t phase, next_phase;
    logic [1:0] holdCount, next_holdCount;
    logic [STRAP_WIDTH-1:0] next_ratioCode;
    logic next_ratioValid;
    logic [STRAP_WIDTH-1:0] compat, next_compat;
    logic [STRAP_WIDTH-1:0] syncA, syncB;

    // Phase and ratio capture
    always_comb begin
        next_phase = phase;
        next_holdCount = holdCount;
        next_ratioCode = ratioCode;
        next_ratioValid = ratioValid;
        case (phase)
            PH_RESET: begin
                next_ratioCode = link.strapPins;
                next_holdCount = '0;
                if (link.systemReset_n) begin
                    next_phase = PH_HOLD;
                end
            end
            PH_HOLD: begin
                next_ratioCode = link.strapPins;
                if (!link.systemReset_n) begin
                    next_phase = PH_RESET;
                end else if (holdCount == HOLD_LAST) begin
                    next_phase = PH_RUN;
                    next_ratioValid = 1'b1;
                end else begin
                    next_holdCount = holdCount + 2'h1;
                end
            end
            PH_RUN: begin
                if (!link.systemReset_n) begin
                    next_phase = PH_RESET;
                    next_ratioValid = 1'b0;
                end
            end
            default: next_phase = PH_RESET;
        endcase
    end

    // Sampled on the bus clock rising edge only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PH_RESET;
            holdCount <= '0;
            ratioCode <= STRAP_SAFE_CODE;
            ratioValid <= 1'b0;
        end else begin
            phase <= next_phase;
            holdCount <= next_holdCount;
            ratioCode <= next_ratioCode;
            ratioValid <= next_ratioValid;
        end
    end

    // Two-stage synchroniser for asynchronous sideband use
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= '0;
            syncB <= '0;
        end else begin
            syncA <= link.strapPins;
            syncB <= syncA;
        end
    end

    // Redundant pair already gets synchronised pins, skip the extra latency
    always_comb begin
        next_compat = redundant_pair_mode ? link.strapPins : syncB;
        if (phase != PH_RUN) begin
            next_compat = compat;
        end
    end

    // Compatibility outputs, idle (inactive) from rst_n until the first sampling ends; later resets hold the last values
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            compat <= 4'h3;
            addr_wrap_mask_n <= 1'b1;
            ignore_numeric_error_n <= 1'b1;
            local_irq0_maskable <= 1'b0;
            local_irq1_nonmaskable <= 1'b0;
            powerStableSeen <= 1'b0;
            interruptTick <= 1'b0;
        end else begin
            compat <= next_compat;
            addr_wrap_mask_n <= next_compat[BIT_ADDR_WRAP];
            ignore_numeric_error_n <= next_compat[BIT_IGNORE_NUM];
            local_irq0_maskable <= next_compat[BIT_IRQ0];
            local_irq1_nonmaskable <= next_compat[BIT_IRQ1];
            powerStableSeen <= link.powerStable;
            interruptTick <= link.interruptBusClockEn;
        end
    end
endmodule
`default_nettype wire

//--- pkg/ratio_strap_pkg.sv
// Shared constants and types for the core ratio strap link.
// Assumes a single bus clock domain at 20 MHz and an active-low reset.
package ratio_strap_pkg;
    // Strap code width and the safe default code (2x)
    localparam int STRAP_WIDTH = 4;
    localparam logic [3:0] STRAP_SAFE_CODE = 4'h0;
    // Bus clocks the strap code must stay valid after reset release
    localparam int STRAP_HOLD_CLOCKS = 2;
    // Interrupt-bus clock is one quarter of the bus clock
    localparam int IRQ_CLK_DIVIDE = 4;
    // Bit positions inside the shared strap group
    localparam int BIT_ADDR_WRAP = 0;
    localparam int BIT_IGNORE_NUM = 1;
    localparam int BIT_IRQ0 = 2;
    localparam int BIT_IRQ1 = 3;
    // Device-side sampling phases
    typedef enum logic [2:0] {
        PH_RESET = 3'b001,
        PH_HOLD = 3'b010,
        PH_RUN = 3'b100
    } phase_t;
endpackage

//--- pkg/ratio_strap_if.sv
// Pin bundle between the processor strap logic and the board multiplexer.
// Assumes both ends share clock; pins are plain synchronous levels.
`timescale 1ns/1ps
`default_nettype none
interface ratio_strap_if;
    import ratio_strap_pkg::*;
    logic [STRAP_WIDTH-1:0] strapPins;
    logic systemReset_n;
    logic powerStable;
    logic interruptBusClockEn;
    modport device (input strapPins, input systemReset_n, input powerStable,
        input interruptBusClockEn);
    modport board (output strapPins, output systemReset_n, output powerStable,
        output interruptBusClockEn);
endinterface
`default_nettype wire

//--- verilog/ratio_strap_board.sv
// Board end: drives reset, muxes ratio code or compatibility signals onto
// the shared pins, and in redundant mode synchronises sidebands and makes the quarter-rate tick.
// Assumes the same bus clock as the processor end.
`timescale 1ns/1ps
`default_nettype none
module ratio_strap_board
    import ratio_strap_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // System controls
    input wire logic systemResetReq,
    input wire logic cmos_domain_reset_n,
    input wire logic redundant_pair_mode,
    input wire logic power_stable_in,
    input wire logic [STRAP_WIDTH-1:0] ratioSelect,
    // Compatibility sources
    input wire logic addr_wrap_mask_n,
    input wire logic ignore_numeric_error_n,
    input wire logic local_irq0_maskable,
    input wire logic local_irq1_nonmaskable,
    // Link to processor
    ratio_strap_if.board link
);
    logic resetOut, next_resetOut;
    logic [1:0] releaseCount, next_releaseCount;
    logic muxCompat, next_muxCompat;
    logic [STRAP_WIDTH-1:0] pins, next_pins;
    logic [STRAP_WIDTH-1:0] syncA, syncB;
    logic [1:0] divCount, next_divCount;
    logic tick, next_tick;
    logic [STRAP_WIDTH-1:0] compatRaw;

    assign compatRaw = {local_irq1_nonmaskable, local_irq0_maskable,
        ignore_numeric_error_n, addr_wrap_mask_n};

    // Sideband synchroniser; power-stable bypasses it
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            syncA <= 4'h3;
            syncB <= 4'h3;
        end else begin
            syncA <= compatRaw;
            syncB <= syncA;
        end
    end

    // Reset, mux select and pin drive; ratio code only changes under reset
    always_comb begin
        next_resetOut = systemResetReq;
        next_releaseCount = releaseCount;
        next_muxCompat = muxCompat;
        if (systemResetReq || !cmos_domain_reset_n) begin
            next_releaseCount = '0;
            next_muxCompat = 1'b0;
        // Processor still samples at the second edge after release; switch one edge later
        end else if (releaseCount != 2'(STRAP_HOLD_CLOCKS + 1)) begin
            next_releaseCount = releaseCount + 2'h1;
        end else begin
            next_muxCompat = 1'b1;
        end
        if (next_muxCompat) begin
            next_pins = redundant_pair_mode ? syncB : compatRaw;
        end else begin
            next_pins = ratioSelect;
        end
        next_divCount = divCount + 2'h1;
        next_tick = redundant_pair_mode && (divCount == 2'(IRQ_CLK_DIVIDE - 1));
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            resetOut <= 1'b1;
            releaseCount <= '0;
            muxCompat <= 1'b0;
            pins <= STRAP_SAFE_CODE;
            divCount <= '0;
            tick <= 1'b0;
        end else begin
            resetOut <= next_resetOut;
            releaseCount <= next_releaseCount;
            muxCompat <= next_muxCompat;
            pins <= next_pins;
            divCount <= next_divCount;
            tick <= next_tick;
        end
    end

    assign link.strapPins = pins;
    assign link.systemReset_n = !resetOut;
    assign link.powerStable = power_stable_in;
    assign link.interruptBusClockEn = tick;
endmodule
`default_nettype wire

//--- tb/ratio_strap_props.sv
// Checker on the link between the processor and board ends.
// Assumes the link signals as plain inputs in the bus clock domain.
`timescale 1ns/1ps
`default_nettype none
module ratio_strap_props
    import ratio_strap_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Link signals
    input wire logic [STRAP_WIDTH-1:0] strapPins,
    input wire logic systemReset_n,
    input wire logic powerStable,
    input wire logic interruptBusClockEn
);
    logic firstEdge;
    // Marks the first edge after reset release
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            firstEdge <= 1'b1;
        end else begin
            firstEdge <= 1'b0;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    safe_code_a: assert property (firstEdge |-> strapPins == STRAP_SAFE_CODE)
        else $error("Straps not at safe code after reset");
    reset_held_a: assert property (firstEdge |-> !systemReset_n)
        else $error("System reset not held after reset");
    tick_idle_a: assert property (firstEdge |-> !interruptBusClockEn)
        else $error("Interrupt tick right after reset");
    strap_hold_a: assert property ($rose(systemReset_n) |-> $stable(strapPins)[*2])
        else $error("Strap code moved inside hold window");
    strap_switch_a: assert property (!$stable(strapPins) && systemReset_n |->
        $past(systemReset_n, 1) && $past(systemReset_n, 2)) else $error("Early mux switch");
    // Settling margin: the board may synchronise its select first
    strap_steady_a: assert property ((!systemReset_n)[*6] |-> $stable(strapPins))
        else $error("Straps moved while reset held");
    tick_gap_a: assert property (interruptBusClockEn |=> (!interruptBusClockEn)[*3])
        else $error("Interrupt ticks closer than four clocks");
    reset_min_a: assert property ($fell(systemReset_n) |=> !systemReset_n)
        else $error("System reset pulse too short");
endmodule
`default_nettype wire

//--- tb/core_ratio_strap_and_sync_tb_top.sv
// Bench joining the processor and board ends of the ratio strap link.
// Assumes a 20 MHz bus clock; inputs change 2 ns after each rising edge.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED at %0t: value mismatch", $time); end end
module core_ratio_strap_and_sync_tb_top;
    import ratio_strap_pkg::*;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic resetReq = 1'b1;
    logic cmosReset_n = 1'b0;
    logic pairMode = 1'b0;
    logic powerIn = 1'b0;
    logic [3:0] ratioSel = STRAP_SAFE_CODE;
    logic [3:0] compat = 4'hF;
    logic [3:0] outs;
    logic [3:0] ratioCode;
    logic ratioValid, pwrSeen, tick;
    logic [3:0] expQ[$];
    int mismatches = 0;
    int n_checks = 0;
    int cnt;
    // Bus clock, 50 ns period
    always #25 clock = ~clock;
    ratio_strap_if link();
    ratio_strap_board i_ratio_strap_board (.clock(clock), .rst_n(rst_n),
        .systemResetReq(resetReq), .cmos_domain_reset_n(cmosReset_n),
        .redundant_pair_mode(pairMode), .power_stable_in(powerIn), .ratioSelect(ratioSel),
        .addr_wrap_mask_n(compat[0]), .ignore_numeric_error_n(compat[1]),
        .local_irq0_maskable(compat[2]), .local_irq1_nonmaskable(compat[3]),
        .link(link.board));
    ratio_strap_device i_ratio_strap_device (.clock(clock), .rst_n(rst_n),
        .link(link.device), .redundant_pair_mode(pairMode), .ratioCode(ratioCode),
        .ratioValid(ratioValid), .addr_wrap_mask_n(outs[0]), .ignore_numeric_error_n(outs[1]),
        .local_irq0_maskable(outs[2]), .local_irq1_nonmaskable(outs[3]),
        .powerStableSeen(pwrSeen), .interruptTick(tick));
    ratio_strap_props i_ratio_strap_props (.clock(clock), .rst_n(rst_n),
        .strapPins(link.strapPins), .systemReset_n(link.systemReset_n),
        .powerStable(link.powerStable), .interruptBusClockEn(link.interruptBusClockEn));
    // Wait whole cycles, then step just past the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask
    // One reset with a ratio code; compat inputs churn to prove they are ignored
    task automatic strap(input logic [3:0] code);
        cmosReset_n = 1'b0;
        ratioSel = code;
        cyc(6);
        resetReq = 1'b1;
        repeat (6) begin
            compat = $urandom;
            cyc(1);
        end
        `CHK(ratioValid, 1'b0)
        expQ.push_back(code);
        resetReq = 1'b0;
        cmosReset_n = 1'b1;
        repeat (10) begin
            compat = $urandom;
            cyc(1);
        end
    endtask
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Each new valid code is matched against the oldest noted one
    always @(posedge ratioValid) begin
        #1;
        `CHK(expQ.size() > 0, 1'b1)
        if (expQ.size() > 0) begin
            `CHK(ratioCode, expQ.pop_front())
        end
    end
    // Main sequence: every code in both modes
    initial begin
        void'($urandom(32'h24C40D7B));
        cyc(10);
        rst_n = 1'b1;
        for (int m = 0; m < 2; m++) begin
            pairMode = m[0];
            for (int c = 0; c < 16; c++) begin
                strap(c[3:0]);
                compat = $urandom;
                powerIn = $urandom;
                cyc(8);
                `CHK(outs, compat)
                `CHK(pwrSeen, powerIn)
            end
            cnt = 0;
            repeat (40) begin
                cyc(1);
                if (tick === 1'b1) cnt++;
            end
            `CHK(cnt, m * 40 / IRQ_CLK_DIVIDE)
        end
        `CHK(expQ.size(), 0)
        stop_test();
    end
    // Watchdog, well beyond the expected 1050 cycles
    initial begin
        #300000;
        mismatches++;
        stop_test();
    end
endmodule
`default_nettype wire
